// ### verilog/efp_pkg.sv
// constants and types shared by the flash program and erase sequencer
package efp_pkg;
  // array organisation: three code banks plus one data bank, 4 Kbytes each
  localparam int unsigned BANK_BYTES = 4096;
  localparam int unsigned NUM_BANKS = 4;
  localparam logic [1:0] DATA_BANK = 2'h3;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned BANK_LSB = 12;
  localparam int unsigned WL_BYTES = 32;
  localparam int unsigned WL_W = 9;
  localparam int unsigned WL_BANK_LSB = 7;
  // sector map: two sectors per code bank, eight finer sectors in the data bank
  localparam int unsigned P_SECS_PER_BANK = 2;
  localparam int unsigned NUM_PBANKS = 3;
  localparam int unsigned D_SECS = 8;
  localparam int unsigned NUM_SECS = P_SECS_PER_BANK * NUM_PBANKS + D_SECS;
  // stored word: data byte in the low bits, check nibble above
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHK_W = 4;
  localparam int unsigned CODE_W = DATA_W + CHK_W;
  localparam int unsigned CHK_LSB = 8;
  // timing at the 40 MHz system clock
  localparam int unsigned CLK_PS = 25000;
  localparam int unsigned READ_TIME_PS = 112500;
  localparam int unsigned PROG_TIME_NS = 2600000;
  localparam int unsigned ERASE_TIME_NS = 102000000;
  localparam int unsigned CLK_NS = CLK_PS / 1000;
  localparam int unsigned READ_CYC = (READ_TIME_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned PROG_CYC = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ERASE_CYC = (ERASE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned RCNT_W = 3;

  typedef enum logic [2:0] {
    EFP_IDLE = 3'h1,
    EFP_PROG = 3'h2,
    EFP_ERASE = 3'h4
  } efp_op_e;

  typedef struct packed {
    efp_op_e op;
    logic [CNT_W-1:0] cnt;
    logic [NUM_BANKS-1:0] bank_busy;
    logic busy;
    logic done;
    logic aborted;
    logic refused;
    logic pg;
    logic [WL_W-1:0] pg_wl;
    logic [WL_BYTES*CODE_W-1:0] pg_data;
    logic er;
    logic [NUM_SECS-1:0] er_mask;
    logic rd_act;
    logic [RCNT_W-1:0] rd_cnt;
    logic [ADDR_W-1:0] raddr;
    logic [DATA_W-1:0] rdata;
    logic rd_ack;
    logic rd_fixed;
    logic rd_refused;
  } efp_st_s;
endpackage

// ### verilog/efp_ecc_if.sv
// byte to check-nibble link between the sequencer and one encoder
`timescale 1ns/100ps
`default_nettype none
interface efp_ecc_if;
  logic [7:0] data;
  logic [3:0] chk;
  modport user (output data, input chk);
  modport coder (input data, output chk);
endinterface
`default_nettype wire

// ### verilog/efp_ecc_byte.sv
// check-nibble encoder for one byte, single-error-correcting code
`timescale 1ns/100ps
`default_nettype none
module efp_ecc_byte (
  efp_ecc_if.coder link // byte in, check nibble out
);
  // all-zero byte gives all-zero check, so erased cells decode as zero
  assign link.chk[0] = link.data[0] ^ link.data[1] ^ link.data[3] ^ link.data[4] ^ link.data[6];
  assign link.chk[1] = link.data[0] ^ link.data[2] ^ link.data[3] ^ link.data[5] ^ link.data[6];
  assign link.chk[2] = link.data[1] ^ link.data[2] ^ link.data[3] ^ link.data[7];
  assign link.chk[3] = link.data[4] ^ link.data[5] ^ link.data[6] ^ link.data[7];
endmodule
`default_nettype wire

// ### verilog/efp_seq.sv
// flash program, erase and corrected-read sequencer
`timescale 1ns/100ps
`default_nettype none
// Function
// - program only whole 32-byte wordlines
// - erase whole sectors, singly or together
// - erased cells read back as zero
// - no single wordline erase exists
// - correct single-bit errors while reading
// - program and erase run in background
// - erase in progress can be aborted
// - four 4-Kbyte banks, one data bank
module efp_seq
  import efp_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC, // program duration
  parameter int unsigned ERASE_CYCLES = ERASE_CYC // erase duration
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic rd_req, // read request
  input wire logic [ADDR_W-1:0] rd_addr, // read byte address
  output logic rd_ack, // read data valid pulse
  output logic [DATA_W-1:0] rd_data, // corrected read byte
  output logic rd_fixed, // a bit was corrected
  output logic rd_refused, // read hit a busy bank
  input wire logic pg_req, // program wordline request
  input wire logic [WL_W-1:0] pg_wl, // wordline index
  input wire logic [WL_BYTES*DATA_W-1:0] pg_data, // wordline data
  input wire logic er_req, // sector erase request
  input wire logic [NUM_SECS-1:0] er_mask, // sectors to erase
  input wire logic er_abort, // abort running erase
  output logic busy, // operation running
  output logic op_done, // operation ended pulse
  output logic op_aborted, // erase was aborted pulse
  output logic req_refused, // request refused pulse
  output logic [ADDR_W-1:0] arr_raddr, // array read address
  input wire logic [CODE_W-1:0] arr_rdata, // array read word
  output logic arr_pg, // array program strobe level
  output logic [WL_W-1:0] arr_pg_wl, // array program wordline
  output logic [WL_BYTES*CODE_W-1:0] arr_pg_data, // array program words
  output logic arr_er, // array erase level
  output logic [NUM_SECS-1:0] arr_er_mask // array erase sectors
);
  efp_st_s s_q;
  efp_st_s s_d;
  logic [WL_BYTES*CODE_W-1:0] enc_word;
  logic [CHK_W-1:0] rd_chk;
  logic [CHK_W-1:0] syn;
  logic [DATA_W-1:0] rd_fix_data;
  logic [NUM_BANKS-1:0] er_banks;

  efp_ecc_if enc_if [WL_BYTES+1] ();

  // one encoder per wordline byte, plus one for read checking
  for (genvar g = 0; g < WL_BYTES; g++) begin : g_enc
    assign enc_if[g].data = pg_data[g*DATA_W +: DATA_W];
    assign enc_word[g*CODE_W +: CODE_W] = {enc_if[g].chk, pg_data[g*DATA_W +: DATA_W]};
    efp_ecc_byte u_enc (
      .link(enc_if[g])
    );
  end
  assign enc_if[WL_BYTES].data = arr_rdata[DATA_W-1:0];
  assign rd_chk = enc_if[WL_BYTES].chk;
  efp_ecc_byte u_rd_enc (
    .link(enc_if[WL_BYTES])
  );

  // syndrome points at the flipped bit position
  assign syn = rd_chk ^ arr_rdata[CHK_LSB +: CHK_W];
  always_comb begin
    rd_fix_data = arr_rdata[DATA_W-1:0];
    case (syn)
      4'h3: rd_fix_data[0] = ~arr_rdata[0];
      4'h5: rd_fix_data[1] = ~arr_rdata[1];
      4'h6: rd_fix_data[2] = ~arr_rdata[2];
      4'h7: rd_fix_data[3] = ~arr_rdata[3];
      4'h9: rd_fix_data[4] = ~arr_rdata[4];
      4'hA: rd_fix_data[5] = ~arr_rdata[5];
      4'hB: rd_fix_data[6] = ~arr_rdata[6];
      4'hC: rd_fix_data[7] = ~arr_rdata[7];
      default: rd_fix_data = arr_rdata[DATA_W-1:0];
    endcase
  end

  // banks touched by a sector erase mask
  always_comb begin
    er_banks = '0;
    for (int i = 0; i < NUM_SECS; i++) begin
      if (er_mask[i]) begin
        if (i < P_SECS_PER_BANK * NUM_PBANKS) begin
          er_banks[i / P_SECS_PER_BANK] = 1'b1;
        end else begin
          er_banks[DATA_BANK] = 1'b1;
        end
      end
    end
  end

  // operation sequencer and read path
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.aborted = 1'b0;
    s_d.refused = 1'b0;
    s_d.rd_ack = 1'b0;
    s_d.rd_refused = 1'b0;
    case (s_q.op)
      EFP_IDLE: begin
        if (pg_req) begin
          s_d.op = EFP_PROG;
          s_d.cnt = '0;
          s_d.busy = 1'b1;
          s_d.pg = 1'b1;
          s_d.pg_wl = pg_wl;
          s_d.pg_data = enc_word;
          s_d.bank_busy = '0;
          s_d.bank_busy[pg_wl[WL_BANK_LSB +: 2]] = 1'b1;
        end else if (er_req) begin
          if (er_mask == '0) begin
            s_d.refused = 1'b1;
          end else begin
            s_d.op = EFP_ERASE;
            s_d.cnt = '0;
            s_d.busy = 1'b1;
            s_d.er = 1'b1;
            s_d.er_mask = er_mask;
            s_d.bank_busy = er_banks;
          end
        end
      end
      EFP_PROG: begin
        s_d.refused = pg_req | er_req;
        if (s_q.cnt == CNT_W'(PROG_CYCLES - 1)) begin
          s_d.op = EFP_IDLE;
          s_d.pg = 1'b0;
          s_d.busy = 1'b0;
          s_d.bank_busy = '0;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      EFP_ERASE: begin
        s_d.refused = pg_req | er_req;
        if (er_abort || s_q.cnt == CNT_W'(ERASE_CYCLES - 1)) begin
          s_d.op = EFP_IDLE;
          s_d.er = 1'b0;
          s_d.er_mask = '0;
          s_d.busy = 1'b0;
          s_d.bank_busy = '0;
          s_d.done = 1'b1;
          s_d.aborted = er_abort;
        end else begin
          s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      default: begin
        s_d.op = EFP_IDLE;
        s_d.pg = 1'b0;
        s_d.er = 1'b0;
        s_d.busy = 1'b0;
        s_d.bank_busy = '0;
      end
    endcase
    // reads run beside the sequencer on banks that are not busy
    if (s_q.rd_act) begin
      if (s_q.rd_cnt == RCNT_W'(READ_CYC - 1)) begin
        s_d.rd_act = 1'b0;
        s_d.rdata = rd_fix_data;
        s_d.rd_fixed = (syn != '0);
        s_d.rd_ack = 1'b1;
      end else begin
        s_d.rd_cnt = s_q.rd_cnt + RCNT_W'(1);
      end
    end else if (rd_req) begin
      if (s_q.bank_busy[rd_addr[BANK_LSB +: 2]]) begin
        s_d.rd_refused = 1'b1;
      end else begin
        s_d.rd_act = 1'b1;
        s_d.rd_cnt = '0;
        s_d.raddr = rd_addr;
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{op: EFP_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign rd_ack = s_q.rd_ack;
  assign rd_data = s_q.rdata;
  assign rd_fixed = s_q.rd_fixed;
  assign rd_refused = s_q.rd_refused;

  // operation status
  assign busy = s_q.busy;
  assign op_done = s_q.done;
  assign op_aborted = s_q.aborted;
  assign req_refused = s_q.refused;

  // array read and program drive
  assign arr_raddr = s_q.raddr;
  assign arr_pg = s_q.pg;
  assign arr_pg_wl = s_q.pg_wl;
  assign arr_pg_data = s_q.pg_data;

  // array erase drive
  assign arr_er = s_q.er;
  assign arr_er_mask = s_q.er_mask;
endmodule
`default_nettype wire

// ### test/efp_seq_assertions.sv
// port assertions for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module efp_seq_assertions #(
  parameter int unsigned PROG_CYCLES = 20, // program time
  parameter int unsigned ERASE_CYCLES = 40 // erase time
) (
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic rd_req, // read
  input wire logic rd_ack, // read done
  input wire logic pg_req, // program
  input wire logic er_req, // erase
  input wire logic [13:0] er_mask, // sectors
  input wire logic er_abort, // abort
  input wire logic busy, // running
  input wire logic op_done, // ended
  input wire logic op_aborted, // aborted
  input wire logic req_refused, // refused
  input wire logic arr_pg, // program level
  input wire logic arr_er // erase level
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // requests taken while idle
  sequence s_pg; !busy && pg_req; endsequence
  sequence s_er; !busy && !pg_req && er_req && |er_mask; endsequence
  a_pg_start: assert property (s_pg |=> busy && arr_pg && !arr_er) else $error("no program");
  a_er_start: assert property (s_er |=> busy && arr_er && !arr_pg) else $error("no erase");
  a_pg_hold: assert property (s_pg |=> arr_pg [*8]) else $error("program short");
  a_zero_mask: assert property (!busy && !pg_req && er_req && er_mask == 14'h0 |=> req_refused && !busy)
    else $error("empty erase taken");
  a_busy_refuse: assert property (busy && pg_req |=> req_refused) else $error("no refusal");
  a_abort_er: assert property (arr_er && er_abort |=> op_done && op_aborted && !arr_er) else $error("no abort");
  a_abort_pg: assert property (arr_pg && er_abort |=> !op_aborted) else $error("program aborted");
  a_busy_end: assert property ($fell(busy) |-> op_done) else $error("busy fell alone");
  a_read_lat: assert property (rd_ack |-> $past(rd_req, 6)) else $error("read latency");
  // cycles the program and erase levels have stood
  logic [31:0] pg_len;
  logic [31:0] er_len;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pg_len <= '0;
      er_len <= '0;
    end else begin
      pg_len <= arr_pg ? pg_len + 32'h1 : '0;
      er_len <= arr_er ? er_len + 32'h1 : '0;
    end
  end
  a_pg_len: assert property ($fell(arr_pg) |-> pg_len == 32'(PROG_CYCLES)) else $error("program length");
  a_er_len: assert property ($fell(arr_er) && !op_aborted |-> er_len == 32'(ERASE_CYCLES))
    else $error("erase length");
endmodule
bind efp_seq efp_seq_assertions #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .rd_req(rd_req), .rd_ack(rd_ack), .pg_req(pg_req), .er_req(er_req),
  .er_mask(er_mask), .er_abort(er_abort), .busy(busy), .op_done(op_done), .op_aborted(op_aborted),
  .req_refused(req_refused), .arr_pg(arr_pg), .arr_er(arr_er));
`default_nettype wire

// ### test/efp_array_model.sv
// array model behind the sequencer, erased cells read zero
`timescale 1ns/100ps
`default_nettype none
module efp_array_model (
  input wire logic [13:0] arr_raddr, // read address
  output logic [11:0] arr_rdata, // read word
  input wire logic arr_pg, // program level
  input wire logic [8:0] arr_pg_wl, // wordline
  input wire logic [383:0] arr_pg_data, // words
  input wire logic arr_er, // erase level
  input wire logic [13:0] arr_er_mask, // sectors
  input wire logic flip_en, // corrupt reads
  input wire logic [2:0] flip_bit // bit to corrupt
);
  logic [11:0] mem [16384];
  int s;
  initial foreach (mem[i]) mem[i] = 12'h000;
  // a whole wordline at once, after wordline and data have settled; cells only gain ones
  always @(posedge arr_pg) begin
    #1;
    for (int g = 0; g < 32; g++) begin
      mem[{arr_pg_wl, g[4:0]}] = mem[{arr_pg_wl, g[4:0]}] | arr_pg_data[12*g +: 12];
    end
  end
  // whole sectors only, several at once, after the mask has settled
  always @(posedge arr_er) begin
    #1;
    foreach (mem[i]) begin
      s = (i >> 12) == 3 ? 6 + ((i >> 9) & 7) : 2 * (i >> 12) + ((i >> 11) & 1);
      if (arr_er_mask[s]) mem[i] = 12'h000;
    end
  end
  // optional single data bit error on read
  assign arr_rdata = mem[arr_raddr] ^ {4'h0, 8'h01 << flip_bit} & {12{flip_en}};
endmodule
`default_nettype wire

// ### test/efp_seq_test.sv
// self-checking bench for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module efp_seq_test;
  import efp_pkg::*;
  logic clk = 0, sys_rst = 1, rd_req = 0, pg_req = 0, er_req = 0, er_abort = 0, flip_en = 0;
  logic [13:0] rd_addr = '0, er_mask = '0, arr_raddr, arr_er_mask;
  logic [8:0] pg_wl = '0, arr_pg_wl;
  logic [255:0] pg_data = '0;
  logic [383:0] arr_pg_data;
  logic [11:0] arr_rdata;
  logic [7:0] rd_data;
  logic [2:0] flip_bit = '0;
  logic [127:0] keep;
  logic rd_ack, rd_fixed, rd_refused, busy, op_done, op_aborted, req_refused, arr_pg, arr_er;
  logic [31:0] rs = 32'h0000EAD6;
  logic [9:0] rq [$];
  logic [1:0] oq [$];
  int mismatches = 0, check_count = 0;
  always #12.5 clk = ~clk;
  efp_seq #(.PROG_CYCLES(20), .ERASE_CYCLES(40)) dut (.*);
  efp_array_model u_arr (.*);
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk_rd(input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (e !== g) begin
      mismatches++;
      $display("FAIL t=%0t read exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_op(input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (e !== g) begin
      mismatches++;
      $display("FAIL t=%0t op exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic stop_test();
    mismatches += rq.size() + oq.size();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [13:0] a, input logic [9:0] e);
    rq.push_back(e);
    @(negedge clk) rd_req = 1;
    rd_addr = a;
    @(negedge clk) rd_req = 0;
    repeat (7) @(negedge clk);
  endtask
  task automatic op(input logic p, input logic e, input logic [13:0] m, input int ab, input logic [1:0] x);
    int n;
    if (p) oq.push_back(2'h2);
    oq.push_back(x);
    @(negedge clk) pg_req = p;
    er_req = e;
    er_mask = m;
    @(negedge clk) pg_req = 0;
    er_req = 0;
    if (p) begin
      rd({pg_wl, 5'h00}, 10'h200);
      @(negedge clk) pg_req = 1;
      @(negedge clk) pg_req = 0;
    end
    if (ab > 0) begin
      repeat (ab) @(negedge clk);
      er_abort = 1;
      @(negedge clk) er_abort = 0;
    end
    for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge clk);
    if (n == 100) begin
      mismatches++;
      stop_test();
    end
    repeat (2) @(negedge clk);
  endtask
  // results are matched against the oldest note
  always @(negedge clk) begin
    if (rd_ack === 1'b1 || rd_refused === 1'b1)
      chk_rd(rq.size() ? rq.pop_front() : 10'h3FF, {rd_refused, rd_ack ? {rd_fixed, rd_data} : 9'h000});
    if (op_done === 1'b1 || req_refused === 1'b1)
      chk_op(oq.size() ? oq.pop_front() : 2'h3, {req_refused, op_aborted});
  end
  // main sequence
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 0;
    rd(14'h00A0, 10'h000);
    pg_wl = 9'h005;
    for (int i = 0; i < 8; i++) pg_data[32*i +: 32] = xs();
    op(1, 0, 14'h0000, 0, 2'h0);
    for (int g = 0; g < 32; g++) begin
      flip_en = g[0];
      flip_bit = g[3:1];
      rd({pg_wl, g[4:0]}, {1'b0, g[0], pg_data[8*g +: 8]});
    end
    flip_en = 0;
    pg_wl = 9'h180;
    op(1, 0, 14'h0000, 3, 2'h0);
    op(0, 1, 14'h0041, 0, 2'h0);
    rd(14'h00A3, 10'h000);
    rd(14'h3000, 10'h000);
    keep = pg_data[127:0];
    pg_data[255:128] = '0;
    op(1, 1, 14'h3FFF, 0, 2'h0);
    pg_data[127:0] = '0;
    for (int i = 4; i < 8; i++) pg_data[32*i +: 32] = xs();
    op(1, 0, 14'h0000, 0, 2'h0);
    rd(14'h3000, {2'h0, keep[7:0]});
    rd(14'h301F, {2'h0, pg_data[255:248]});
    op(0, 1, 14'h0000, 0, 2'h2);
    op(0, 1, 14'h0002, 5, 2'h1);
    stop_test();
  end
endmodule
`default_nettype wire
